// [wdt_cfg.svh]
// Timing counts, encodings and reset values for the watchdog timer
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

`define WDT_FEED_FIRST     8'h1E
`define WDT_FEED_SECOND    8'hE1
`define WDT_SEL_W          3
`define WDT_SEL_RESET      3'h7
`define WDT_CNT_W          32
`define WDT_RST_PULSE_NS   1000
`define WDT_CLK_NS         20
`define WDT_RST_PULSE_CYC  (`WDT_RST_PULSE_NS / `WDT_CLK_NS)
`define WDT_PULSE_W        8
`define WDT_STAB_CYC       16'h0100
`define WDT_STAB_W         16

`endif

// [wdt_pkg.sv]
// Types shared by the watchdog timer
package wdt_pkg;
  typedef enum logic [1:0] {
    WDT_RUN   = 2'h0,
    WDT_PULSE = 2'h1,
    WDT_STAB  = 2'h3
  } wdt_state_t;
endpackage : wdt_pkg

// [wdt_timer.sv]
// Watchdog and interval timer with two-write feed sequence
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module wdt_timer (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  reset_in,
  input  wire logic                  clk_en_in,
  // Configuration and other reset sources
  input  wire logic                  watchdog_enable_cfg_in,
  input  wire logic                  other_reset_in,
  // Tick from the independent on-chip oscillator
  input  wire logic                  wd_osc_tick_in,
  // Register writes from the CPU
  input  wire logic                  ctrl_wr_in,
  input  wire logic [`WDT_SEL_W-1:0] ctrl_sel_in,
  input  wire logic                  feed_wr_in,
  input  wire logic [7:0]            feed_data_in,
  input  wire logic                  irq_en_in,
  input  wire logic                  ovf_clr_in,
  // CPU oscillator state
  input  wire logic                  power_down_in,
  // Outputs
  output logic                       cpu_reset_out,
  output logic                       osc_restart_out,
  output logic                       irq_out,
  output logic                       ovf_flag_out,
  output logic [`WDT_SEL_W-1:0]      timeout_select_out
);

  // Expiry count for each select value, in oscillator ticks
  function automatic logic [`WDT_CNT_W-1:0] period_of(
      input logic [`WDT_SEL_W-1:0] sel);
    logic [`WDT_CNT_W-1:0] p;
    p = 32'h0000_0000;
    unique case (sel)
      3'h0: p = 32'h0000_0019; // 25 ms nominal
      3'h1: p = 32'h0000_0032;
      3'h2: p = 32'h0000_0064;
      3'h3: p = 32'h0000_00C8;
      3'h4: p = 32'h0000_0190;
      3'h5: p = 32'h0000_0320;
      3'h6: p = 32'h0000_0640;
      3'h7: p = 32'h0000_0C80; // 3.2 s nominal
    endcase
    return p;
  endfunction : period_of

  localparam logic [`WDT_PULSE_W-1:0] PULSE_CYC =
    `WDT_PULSE_W'(`WDT_RST_PULSE_CYC);

  wdt_pkg::wdt_state_t             state_ff, nxt_state;
  logic [`WDT_CNT_W-1:0]           cnt_ff, nxt_cnt;
  logic [`WDT_PULSE_W-1:0]         pulse_ff, nxt_pulse;
  logic [`WDT_STAB_W-1:0]          stab_ff, nxt_stab;
  logic [`WDT_SEL_W-1:0]           sel_ff, nxt_sel;
  logic                            locked_ff, nxt_locked;
  logic                            armed_ff, nxt_armed;
  logic                            ovf_ff, nxt_ovf;
  logic                            irq_ff, nxt_irq;
  logic                            rst_ff, nxt_rst;
  logic                            osc_ff, nxt_osc;
  logic                            feed_ok;
  logic                            expire;

  // Feed checker
  always_comb begin
    feed_ok   = 1'b0;
    nxt_armed = armed_ff;
    if (feed_wr_in) begin
      feed_ok   = armed_ff && (feed_data_in == `WDT_FEED_SECOND);
      nxt_armed = (feed_data_in == `WDT_FEED_FIRST);
    end
  end

  assign expire = (cnt_ff >= period_of(sel_ff) - 32'h0000_0001)
                  && wd_osc_tick_in;

  // Timer, control and reset sequencing
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_pulse  = pulse_ff;
    nxt_stab   = stab_ff;
    nxt_sel    = sel_ff;
    nxt_locked = locked_ff;
    nxt_ovf    = ovf_ff;
    nxt_irq    = 1'b0;
    nxt_rst    = rst_ff;
    nxt_osc    = 1'b0;
    if (ctrl_wr_in && !locked_ff) begin
      nxt_sel    = ctrl_sel_in;
      nxt_locked = watchdog_enable_cfg_in;
    end
    if (ovf_clr_in)
      nxt_ovf = 1'b0;
    unique case (state_ff)
      wdt_pkg::WDT_RUN: begin
        if (other_reset_in && watchdog_enable_cfg_in) begin
          nxt_cnt = 32'h0000_0000;
        end else if (feed_ok) begin
          nxt_cnt = 32'h0000_0000;
        end else if (expire) begin
          nxt_cnt = 32'h0000_0000;
          if (watchdog_enable_cfg_in) begin
            nxt_rst   = 1'b1;
            nxt_pulse = PULSE_CYC;
            nxt_state = wdt_pkg::WDT_PULSE;
          end else begin
            nxt_ovf = 1'b1;
            nxt_irq = irq_en_in;
          end
        end else if (wd_osc_tick_in) begin
          nxt_cnt = cnt_ff + 32'h0000_0001;
        end
      end
      wdt_pkg::WDT_PULSE: begin
        nxt_pulse = pulse_ff - 8'h01;
        if (pulse_ff == 8'h01) begin
          if (power_down_in) begin
            nxt_osc   = 1'b1;
            nxt_stab  = `WDT_STAB_CYC;
            nxt_state = wdt_pkg::WDT_STAB;
          end else begin
            nxt_rst   = 1'b0;
            nxt_state = wdt_pkg::WDT_RUN;
          end
        end
      end
      wdt_pkg::WDT_STAB: begin
        nxt_osc  = 1'b1;
        nxt_stab = stab_ff - 16'h0001;
        if (stab_ff == 16'h0001) begin
          nxt_rst   = 1'b0;
          nxt_osc   = 1'b0;
          nxt_state = wdt_pkg::WDT_RUN;
        end
      end
      default: nxt_state = wdt_pkg::WDT_RUN;
    endcase
    if (nxt_rst && !rst_ff) begin
      nxt_sel    = `WDT_SEL_RESET;
      nxt_locked = 1'b0;
    end
    if (nxt_ovf && !ovf_ff)
      nxt_ovf = 1'b1; // Set wins over clear
  end

  // Registers
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff  <= wdt_pkg::WDT_RUN;
      cnt_ff    <= 32'h0000_0000;
      pulse_ff  <= 8'h00;
      stab_ff   <= 16'h0000;
      sel_ff    <= `WDT_SEL_RESET;
      locked_ff <= 1'b0;
      armed_ff  <= 1'b0;
      ovf_ff    <= 1'b0;
      irq_ff    <= 1'b0;
      rst_ff    <= 1'b0;
      osc_ff    <= 1'b0;
    end else if (clk_en_in) begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      pulse_ff  <= nxt_pulse;
      stab_ff   <= nxt_stab;
      sel_ff    <= nxt_sel;
      locked_ff <= nxt_locked;
      armed_ff  <= nxt_armed;
      ovf_ff    <= nxt_ovf;
      irq_ff    <= nxt_irq;
      rst_ff    <= nxt_rst;
      osc_ff    <= nxt_osc;
    end
  end

  assign cpu_reset_out      = rst_ff;
  assign osc_restart_out    = osc_ff;
  assign irq_out            = irq_ff;
  assign ovf_flag_out       = ovf_ff;
  assign timeout_select_out = sel_ff;

endmodule : wdt_timer

// [wdt_timer_props.sv]
// Port assertions for the watchdog timer
`timescale 1ns/1ps
module wdt_props (
  // Block inputs
  input wire logic       clk_in, reset_in, clk_en_in, watchdog_enable_cfg_in,
  input wire logic       other_reset_in, wd_osc_tick_in, ctrl_wr_in,
  input wire logic [2:0] ctrl_sel_in,
  input wire logic       feed_wr_in, irq_en_in, ovf_clr_in, power_down_in,
  input wire logic [7:0] feed_data_in,
  // Block outputs
  input wire logic       cpu_reset_out, osc_restart_out, irq_out, ovf_flag_out,
  input wire logic [2:0] timeout_select_out
);
  logic [8:0] len_ff;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Cycles the internal reset has been high
  always_ff @(posedge clk_in or posedge reset_in)
    if (reset_in) len_ff <= 9'h0;
    else len_ff <= cpu_reset_out ? len_ff + 9'h1 : 9'h0;
  pulse_len_a: assert property (
    $fell(cpu_reset_out) && len_ff != 9'h0 |->
    len_ff == ($past(osc_restart_out) ? 9'h132 : 9'h032)) else $error("pulse");
  osc_in_rst_a: assert property (
    osc_restart_out |-> cpu_reset_out) else $error("restart");
  irq_mode_a: assert property (
    irq_out |-> ovf_flag_out && !watchdog_enable_cfg_in) else $error("irq");
  irq_once_a: assert property (
    irq_out |=> !irq_out) else $error("irq width");
  ovf_keep_a: assert property (
    ovf_flag_out && !ovf_clr_in |=> ovf_flag_out) else $error("ovf");
  no_rst_int_a: assert property (
    !watchdog_enable_cfg_in[*2] |-> !$rose(cpu_reset_out)) else $error("int");
  suspend_a: assert property (
    (watchdog_enable_cfg_in && other_reset_in)[*2] |-> !$rose(cpu_reset_out))
    else $error("suspend");
  sel_src_a: assert property (
    $changed(timeout_select_out) |-> $past(ctrl_wr_in) || cpu_reset_out)
    else $error("select");
  // Main scenarios
  c_rst: cover property ($rose(cpu_reset_out));
  c_osc: cover property ($rose(osc_restart_out));
  c_irq: cover property (irq_out);
endmodule : wdt_props
bind wdt_timer wdt_props i_props (.*);

// [wdt_timer_tb.sv]
// Self-checking bench of the watchdog timer
`timescale 1ns/1ps
module wdt_timer_tb;
  logic clk_in = 1'h0, reset_in = 1'h1, clk_en_in = 1'h1, other_reset_in = 1'h0;
  logic watchdog_enable_cfg_in = 1'h1, wd_osc_tick_in = 1'h0, ctrl_wr_in = 1'h0;
  logic feed_wr_in = 1'h0, irq_en_in = 1'h0, ovf_clr_in = 1'h0;
  logic power_down_in = 1'h0, cpu_reset_out, osc_restart_out, irq_out;
  logic ovf_flag_out;
  logic [2:0] ctrl_sel_in = 3'h0, timeout_select_out;
  logic [7:0] feed_data_in = 8'h0;
  logic [1:0] tdiv = 2'h0;
  int n_errors = 0, cmp_count = 0, n, k;
  logic seen_osc;
  wdt_timer i_dut (.*);
  // Clock, and an oscillator tick every fourth cycle
  initial forever #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    tdiv <= tdiv + 2'h1;
    wd_osc_tick_in <= (tdiv == 2'h3);
  end
  task automatic chk(input logic [8:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic do_reset(input logic wd);
    @(posedge clk_in);
    reset_in <= 1'h1;
    watchdog_enable_cfg_in <= wd;
    power_down_in <= 1'h0;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'h0;
  endtask : do_reset
  // One register write: feed when f is high, else control
  task automatic wr(input logic f, input logic [7:0] d);
    @(posedge clk_in);
    feed_wr_in <= f;
    ctrl_wr_in <= !f;
    feed_data_in <= d;
    ctrl_sel_in <= d[2:0];
    @(posedge clk_in);
    feed_wr_in <= 1'h0;
    ctrl_wr_in <= 1'h0;
  endtask : wr
  // Cycles to the internal reset, then its width
  task automatic wait_rst();
    for (n = 0; cpu_reset_out !== 1'h1 && n < 20000; n++) @(negedge clk_in);
    seen_osc = 1'h0;
    for (k = 0; cpu_reset_out === 1'h1 && k < 400; k++) begin
      seen_osc |= osc_restart_out;
      @(negedge clk_in);
    end
  endtask : wait_rst
  task automatic wait_irq();
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (irq_out !== 1'h1 && n < 2000);
  endtask : wait_irq
  task automatic t_wd();
    do_reset(1'h1);
    wr(1, 8'h1E);
    wr(1, 8'hE1);
    wr(0, 8'h00);
    wr(0, 8'h05);
    repeat (4) begin
      wr(1, 8'h1E);
      wr(0, 8'h02);
      wr(1, 8'hE1);
      repeat (40) @(posedge clk_in);
    end
    chk(timeout_select_out, 3'h0);
    chk(cpu_reset_out, 1'h0);
    wr(1, 8'h1E);
    wr(1, 8'h55);
    wr(1, 8'hE1);
    wait_rst();
    chk(n > 40 && n < 70, 1'h1);
    chk(k, 9'h032);
    chk(seen_osc, 1'h0);
    chk(timeout_select_out, 3'h7);
    @(posedge clk_in);
    power_down_in <= 1'h1;
    wr(0, 8'h00);
    wait_rst();
    chk(k, 9'h132);
    chk(seen_osc, 1'h1);
  endtask : t_wd
  task automatic t_susp();
    do_reset(1'h1);
    wr(0, 8'h00);
    other_reset_in <= 1'h1;
    // Count reset cycles over three timeout periods
    n = 0;
    repeat (300) begin
      @(negedge clk_in);
      if (cpu_reset_out !== 1'h0) n++;
    end
    chk(n, 9'h000);
    @(posedge clk_in);
    other_reset_in <= 1'h0;
    wait_rst();
    chk(n < 115, 1'h1);
  endtask : t_susp
  task automatic t_int();
    do_reset(1'h0);
    irq_en_in <= 1'h1;
    for (int s = 0; s < 4; s++) begin
      wr(0, 8'(s));
      wait_irq();
      wait_irq();
      chk(n > (100 << s) - 5 && n < (100 << s) + 5, 1'h1);
    end
    chk(ovf_flag_out, 1'h1);
    @(posedge clk_in);
    ovf_clr_in <= 1'h1;
    irq_en_in <= 1'h0;
    @(posedge clk_in);
    ovf_clr_in <= 1'h0;
    @(negedge clk_in);
    chk(ovf_flag_out, 1'h0);
    wait_irq();
    chk(irq_out, 1'h0);
    chk(ovf_flag_out, 1'h1);
  endtask : t_int
  task automatic complete_run();
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  // Tests, and a watchdog against hangs
  initial begin
    t_wd();
    t_susp();
    t_int();
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    n_errors++;
    complete_run();
  end
endmodule : wdt_timer_tb
